//--- acc_pkg.sv
package acc_pkg;

  // Register word offsets on the Wishbone slave (byte addresses, one word each).
  localparam logic [7:0] ADDR_PIN_DIS_LOW  = 8'h00;
  localparam logic [7:0] ADDR_PIN_DIS_HIGH = 8'h04;
  localparam logic [7:0] ADDR_AMP0_CTRL    = 8'h08;
  localparam logic [7:0] ADDR_AMP1_CTRL    = 8'h0C;
  localparam logic [7:0] ADDR_CONV_CTRL    = 8'h10;
  localparam logic [7:0] ADDR_RESULT_LOW   = 8'h14;
  localparam logic [7:0] ADDR_RESULT_HIGH  = 8'h18;
  localparam logic [7:0] ADDR_CONV_STATUS  = 8'h1C;

  // Amplifier control field positions.
  localparam int AMP_ON_BIT    = 7;
  localparam int AMP_SHUNT_BIT = 6;
  localparam int AMP_GAIN_LSB  = 4;
  localparam int AMP_SYNC_LSB  = 0;
  localparam logic [7:0] AMP_CTRL_MASK = 8'hF3;

  // Conversion control field positions.
  localparam int CONV_START_BIT   = 0;
  localparam int CONV_REQ_BIT     = 1;
  localparam int CONV_AUTO_BIT    = 2;
  localparam int CONV_REVB_BIT    = 3;
  localparam int CONV_AMPSEL_BIT  = 4;
  localparam int CONV_AMPCH_BIT   = 5;
  localparam logic [7:0] CONV_CTRL_MASK = 8'h3F;

  // Second input-disable register has six live bits.
  localparam logic [7:0] PIN_DIS_HIGH_MASK = 8'h3F;

  // Reset values.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Conversion lengths and sync divider in converter clock cycles.
  localparam int CONV_CYCLES_LOW  = 13;
  localparam int CONV_CYCLES_HIGH = 14;
  localparam int SYNC_DIV         = 8;
  localparam int SAMPLE_CYCLES    = 2;

  // Synchronization source codes.
  typedef enum logic [1:0] {
    ACC_SYNC_DIV8 = 2'h0,
    ACC_SYNC_PSC0 = 2'h1,
    ACC_SYNC_PSC1 = 2'h2,
    ACC_SYNC_PSC2 = 2'h3
  } acc_sync_t;

  // Settings of one amplifier as driven to the analog macro.
  typedef struct packed {
    logic       on;
    logic       shunt;
    logic [1:0] gain;
  } acc_amp_cfg_t;

endpackage

//--- acc_amp_sync.sv
`timescale 1ns/1ps
// One amplifier clock generator: picks the sync source and pulses per event.
module acc_amp_sync
  import acc_pkg::*;
(
  input  wire logic       clk_i,     // System clock.
  input  wire logic       rst_i,     // Synchronous reset, active high.
  input  wire logic       ce_i,      // Clock enable.
  input  wire logic       on_i,      // Amplifier enabled.
  input  wire logic [1:0] sel_i,     // Sync source select.
  input  wire logic       div8_i,    // Divide-by-eight event pulse.
  input  wire logic [2:0] stage_i,   // Synchronised stage controller events.
  output logic            evt_o      // One amplifier clock event.
);

  logic [2:0] stage_d_ff;
  logic       raw;

  // Source select; stage events are rising-edge detected from settled copies.
  always_comb begin
    case (acc_sync_t'(sel_i))
      ACC_SYNC_DIV8: raw = div8_i;
      ACC_SYNC_PSC0: raw = stage_i[0] & ~stage_d_ff[0];
      ACC_SYNC_PSC1: raw = stage_i[1] & ~stage_d_ff[1];
      ACC_SYNC_PSC2: raw = stage_i[2] & ~stage_d_ff[2];
      default:       raw = 1'b0;
    endcase
  end

  // Edge history for the stage events.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage_d_ff <= 3'h0;
    end else if (ce_i) begin
      stage_d_ff <= stage_i;
    end
  end

  // A disabled amplifier ignores its events.
  assign evt_o = raw & on_i;

endmodule // acc_amp_sync

//--- acc_ctrl.sv
`timescale 1ns/1ps
// Operation
// - Low disable bits switch off buffers of pins zero to seven; reads give zero.
// - High disable bits five to zero switch off six buffers; top bits unused.
// - Two-bit sync field picks divide-by-eight or one of three stage events.
// - Start with half-rate clock low lasts 13 converter cycles.
// - Start with half-rate clock high lasts 14 converter cycles.
// - Enabled amplifier amplifies on every sync event regardless of converter.
// - Old revision: request bit sets start bit at next amplifier event.
// - New revision: start bit begins amplified conversion at once.
// - Other channel starts are refused while amplified conversion runs.
// - Auto-trigger starts at first amplifier event after latest trigger.
// - No free running under auto-trigger; software restarts each time.
// - New revision aborts and restarts when amplifier output changes in sample.
// - Amplifier enable bit seven; clearing waits for running conversion end.
// - Shunt bit six shorts the amplifier input; clearing restores it.
// - Gain bits five and four select gain 5, 10, 20 or 40.
// - Result goes to high and low registers, high holding upper bits.
// - Request bit cleared by hardware at real start, or by writing zero.
// - Start bit cleared by hardware at completion; writing zero does nothing.
module acc_ctrl
  import acc_pkg::*;
(
  input  wire logic        clk_i,          // System clock, 50 MHz.
  input  wire logic        rst_i,          // Synchronous reset, active high.
  input  wire logic        ce_i,           // Clock enable; freezes state when low.
  input  wire logic        wb_cyc_i,       // Wishbone cycle.
  input  wire logic        wb_stb_i,       // Wishbone strobe.
  input  wire logic        wb_we_i,        // Wishbone write enable.
  input  wire logic [7:0]  wb_adr_i,       // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,       // Wishbone byte selects.
  input  wire logic [31:0] wb_dat_i,       // Wishbone write data.
  output logic      [31:0] wb_dat_o,       // Wishbone read data.
  output logic             wb_ack_o,       // Wishbone acknowledge.
  input  wire logic        adc_tick_i,     // Converter clock tick, one cycle.
  input  wire logic [2:0]  stage_evt_i,    // Stage controller async events (pins).
  input  wire logic        auto_trig_i,    // Selected auto-trigger event pulse.
  input  wire logic        other_start_i,  // Start request on a plain channel.
  input  wire logic        amp_chg_i,      // Amplifier output changed (analog).
  input  wire logic [9:0]  conv_data_i,    // Converter core result.
  input  wire logic [10:0] pin_raw_i,      // Raw port input levels, pins 0..10.
  output logic      [10:0] pin_in_o,       // Port input bits after gating.
  output logic      [7:0]  buf_off_low_o,  // Buffer disables, pins 0..7.
  output logic      [5:0]  buf_off_high_o, // Buffer disables, second group.
  output acc_amp_cfg_t     amp0_cfg_o,     // Amplifier 0 settings.
  output acc_amp_cfg_t     amp1_cfg_o,     // Amplifier 1 settings.
  output logic             sample_o,       // Converter in sample phase.
  output logic             conv_busy_o,    // Amplified conversion running.
  output logic             other_ok_o      // Plain channel start accepted.
);

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_WAIT,
    ACC_CONV
  } acc_state_t;

  acc_state_t  state_ff;
  logic [7:0]  dis_low_ff;
  logic [7:0]  dis_high_ff;
  logic [7:0]  amp0_ff;
  logic [7:0]  amp1_ff;
  logic [7:0]  conv_ff;
  logic [9:0]  result_ff;
  logic [4:0]  cnt_ff;
  logic [2:0]  div_ff;
  logic        auto_pend_ff;
  logic        ack_ff;
  logic [31:0] rdat_ff;
  logic [2:0]  s1_ff;
  logic [2:0]  s2_ff;
  logic [2:0]  s3_ff;
  logic [2:0]  stage_ok_ff;
  logic [7:0]  amp0_live_ff;
  logic [7:0]  amp1_live_ff;
  logic [10:0] pin_in_ff;
  logic        other_ok_ff;
  logic [4:0]  nxt_cnt;
  logic        wr;
  logic        rd;
  logic        div8_evt;
  logic        half_rate;
  logic        evt0;
  logic        evt1;
  logic        amp_evt;
  logic        start_now;
  logic        done;
  logic        sel_amp1;

  assign wr        = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & ~ack_ff;
  assign rd        = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign sel_amp1  = conv_ff[CONV_AMPSEL_BIT];
  assign half_rate = div_ff[0];
  assign div8_evt  = adc_tick_i & (div_ff == 3'(SYNC_DIV - 1));
  assign amp_evt   = sel_amp1 ? evt1 : evt0;
  assign done      = (state_ff == ACC_CONV) & adc_tick_i & (cnt_ff == 5'h01);

  // Three flops on the stage pins; an edge counts once stages two and three agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff       <= 3'h0;
      s2_ff       <= 3'h0;
      s3_ff       <= 3'h0;
      stage_ok_ff <= 3'h0;
    end else if (ce_i) begin
      s1_ff <= stage_evt_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < 3; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          stage_ok_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  // Converter clock divided by eight; bit zero gives the half-rate phase.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff <= 3'h0;
    end else if (ce_i && adc_tick_i) begin
      div_ff <= div_ff + 3'h1;
    end
  end

  acc_amp_sync u_sync0 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .on_i    (amp0_live_ff[AMP_ON_BIT]),
    .sel_i   (amp0_live_ff[AMP_SYNC_LSB +: 2]),
    .div8_i  (div8_evt),
    .stage_i (stage_ok_ff),
    .evt_o   (evt0)
  );

  acc_amp_sync u_sync1 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .on_i    (amp1_live_ff[AMP_ON_BIT]),
    .sel_i   (amp1_live_ff[AMP_SYNC_LSB +: 2]),
    .div8_i  (div8_evt),
    .stage_i (stage_ok_ff),
    .evt_o   (evt1)
  );

  // Start decision per revision and mode.
  always_comb begin
    start_now = 1'b0;
    if (state_ff == ACC_IDLE && conv_ff[CONV_AMPCH_BIT]) begin
      if (conv_ff[CONV_AUTO_BIT]) begin
        start_now = auto_pend_ff & amp_evt;
      end else if (conv_ff[CONV_REVB_BIT]) begin
        start_now = conv_ff[CONV_START_BIT];
      end else begin
        start_now = conv_ff[CONV_REQ_BIT] & amp_evt;
      end
    end
  end

  // Most recent auto-trigger is held until it starts a conversion at an amplifier event.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_pend_ff <= 1'b0;
    end else if (ce_i) begin
      if (auto_trig_i) begin
        auto_pend_ff <= 1'b1;
      end else if (start_now) begin
        auto_pend_ff <= 1'b0;
      end
    end
  end

  // Cycle count: 13 from a low half-rate phase, 14 from a high one.
  always_comb begin
    nxt_cnt = cnt_ff;
    if (start_now) begin
      nxt_cnt = half_rate ? 5'(CONV_CYCLES_HIGH) : 5'(CONV_CYCLES_LOW);
    end else if (state_ff == ACC_CONV && amp_chg_i && sample_o &&
                 conv_ff[CONV_REVB_BIT]) begin
      nxt_cnt = 5'(CONV_CYCLES_LOW);
    end else if (state_ff == ACC_CONV && adc_tick_i) begin
      nxt_cnt = cnt_ff - 5'h01;
    end
  end

  // Conversion sequencer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ACC_IDLE;
      cnt_ff   <= 5'h00;
    end else if (ce_i) begin
      cnt_ff <= nxt_cnt;
      case (state_ff)
        ACC_IDLE: begin
          if (start_now) begin
            state_ff <= ACC_CONV;
          end
        end
        ACC_CONV: begin
          if (done) begin
            state_ff <= ACC_IDLE;
          end
        end
        default: state_ff <= ACC_IDLE;
      endcase
    end
  end

  // Result capture; upper bits go to the high register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_ff <= 10'h000;
    end else if (ce_i && done) begin
      result_ff <= conv_data_i;
    end
  end

  // Live amplifier settings; a disable waits for the running conversion.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      amp0_live_ff <= REG_RESET;
      amp1_live_ff <= REG_RESET;
    end else if (ce_i) begin
      amp0_live_ff <= amp0_ff;
      amp1_live_ff <= amp1_ff;
      if (state_ff == ACC_CONV && !done) begin
        amp0_live_ff[AMP_ON_BIT] <= amp0_live_ff[AMP_ON_BIT] | amp0_ff[AMP_ON_BIT];
        amp1_live_ff[AMP_ON_BIT] <= amp1_live_ff[AMP_ON_BIT] | amp1_ff[AMP_ON_BIT];
      end
    end
  end

  // Plain registers written over the bus.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dis_low_ff  <= REG_RESET;
      dis_high_ff <= REG_RESET;
      amp0_ff     <= REG_RESET;
      amp1_ff     <= REG_RESET;
    end else if (ce_i && wr) begin
      case (wb_adr_i)
        ADDR_PIN_DIS_LOW:  dis_low_ff  <= wb_dat_i[7:0];
        ADDR_PIN_DIS_HIGH: dis_high_ff <= wb_dat_i[7:0] & PIN_DIS_HIGH_MASK;
        ADDR_AMP0_CTRL:    amp0_ff     <= wb_dat_i[7:0] & AMP_CTRL_MASK;
        ADDR_AMP1_CTRL:    amp1_ff     <= wb_dat_i[7:0] & AMP_CTRL_MASK;
        default:           ;
      endcase
    end
  end

  // Conversion control; hardware sets and clears win over software writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_ff <= REG_RESET;
    end else if (ce_i) begin
      if (wr && wb_adr_i == ADDR_CONV_CTRL) begin
        conv_ff <= (wb_dat_i[7:0] & CONV_CTRL_MASK) |
                   (conv_ff & 8'(1 << CONV_START_BIT));
      end
      if (start_now) begin
        conv_ff[CONV_REQ_BIT]   <= 1'b0;
        conv_ff[CONV_START_BIT] <= 1'b1;
      end
      if (done) begin
        conv_ff[CONV_START_BIT] <= 1'b0;
      end
    end
  end

  // Plain channel starts are refused while the amplified one runs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      other_ok_ff <= 1'b0;
    end else if (ce_i) begin
      other_ok_ff <= other_start_i & (state_ff == ACC_IDLE) & ~start_now;
    end
  end

  // Disabled buffers force their port bits to zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_in_ff <= 11'h000;
    end else if (ce_i) begin
      pin_in_ff[7:0]  <= pin_raw_i[7:0] & ~dis_low_ff;
      pin_in_ff[10:8] <= pin_raw_i[10:8] & ~dis_high_ff[2:0];
    end
  end

  // Bus answer: ack one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_ff  <= rd;
      rdat_ff <= 32'h0000_0000;
      if (rd && !wb_we_i) begin
        case (wb_adr_i)
          ADDR_PIN_DIS_LOW:  rdat_ff[7:0] <= dis_low_ff;
          ADDR_PIN_DIS_HIGH: rdat_ff[7:0] <= dis_high_ff;
          ADDR_AMP0_CTRL:    rdat_ff[7:0] <= amp0_ff;
          ADDR_AMP1_CTRL:    rdat_ff[7:0] <= amp1_ff;
          ADDR_CONV_CTRL:    rdat_ff[7:0] <= conv_ff;
          ADDR_RESULT_LOW:   rdat_ff[7:0] <= result_ff[7:0];
          ADDR_RESULT_HIGH:  rdat_ff[7:0] <= {6'h00, result_ff[9:8]};
          ADDR_CONV_STATUS:  rdat_ff[7:0] <= {6'h00, half_rate, state_ff == ACC_CONV};
          default:           rdat_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Registered outputs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_o    <= 1'b0;
      conv_busy_o <= 1'b0;
    end else if (ce_i) begin
      sample_o    <= (nxt_cnt > 5'(CONV_CYCLES_LOW - SAMPLE_CYCLES)) &&
                     (start_now || state_ff == ACC_CONV) && !done;
      conv_busy_o <= start_now | ((state_ff == ACC_CONV) & ~done);
    end
  end

  assign wb_ack_o       = ack_ff;
  assign wb_dat_o       = rdat_ff;
  assign pin_in_o       = pin_in_ff;
  assign other_ok_o     = other_ok_ff;
  assign buf_off_low_o  = dis_low_ff;
  assign buf_off_high_o = dis_high_ff[5:0];
  // Shunt and gain pass straight to the analog macro.
  assign amp0_cfg_o = {amp0_live_ff[AMP_ON_BIT], amp0_ff[AMP_SHUNT_BIT],
                       amp0_ff[AMP_GAIN_LSB +: 2]};
  assign amp1_cfg_o = {amp1_live_ff[AMP_ON_BIT], amp1_ff[AMP_SHUNT_BIT],
                       amp1_ff[AMP_GAIN_LSB +: 2]};

endmodule // acc_ctrl

//--- acc_ctrl_asserts.sv
`timescale 1ns/1ps
// Port checks of the amplified conversion control; it sees only the top module's pins.
module acc_ctrl_chk
  import acc_pkg::*;
(
  input  wire logic         clk_i,         // Clock.
  input  wire logic         rst_i,         // Reset.
  input  wire logic         wb_cyc_i,      // Bus cycle.
  input  wire logic         wb_stb_i,      // Bus strobe.
  input  wire logic [31:0]  wb_dat_o,      // Read data.
  input  wire logic         wb_ack_o,      // Acknowledge.
  input  wire logic         adc_tick_i,    // Converter tick.
  input  wire logic         other_start_i, // Plain start request.
  input  wire logic         amp_chg_i,     // Amplifier moved.
  input  wire logic [10:0]  pin_in_o,      // Gated pins.
  input  wire logic [7:0]   buf_off_low_o, // Low disables.
  input  wire acc_amp_cfg_t amp0_cfg_o,    // Amplifier 0.
  input  wire acc_amp_cfg_t amp1_cfg_o,    // Amplifier 1.
  input  wire logic         conv_busy_o,   // Busy.
  input  wire logic         other_ok_o     // Plain start taken.
);
  logic [4:0] tick_cnt_ff; // Ticks seen in this conversion.
  logic       chg_ff;      // An abort stretches the length.

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Ticks are counted while busy; the count saturates so a long abort cannot wrap round.
  always_ff @(posedge clk_i) begin
    if (rst_i || !conv_busy_o) begin
      tick_cnt_ff <= 5'h00;
      chg_ff      <= 1'b0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + {4'h0, adc_tick_i && tick_cnt_ff != 5'h1F};
      chg_ff      <= chg_ff || amp_chg_i;
    end
  end

  // Bus answer, pin gating and conversion relations.
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no acknowledge one cycle after a request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data above the low byte is not zero");
  a_pin_gate: assert property ((pin_in_o[7:0] & buf_off_low_o & $past(buf_off_low_o)) == 8'h00)
    else $error("disabled pin reads as one");
  a_conv_length: assert property ($fell(conv_busy_o) && !chg_ff |-> tick_cnt_ff inside {5'h0D, 5'h0E})
    else $error("conversion length is not 13 or 14 ticks");
  a_other_refused: assert property (conv_busy_o && $past(conv_busy_o) |-> !other_ok_o)
    else $error("plain start accepted during amplified conversion");
  a_other_cause: assert property (other_ok_o |-> $past(other_start_i))
    else $error("plain start accepted without a request");
  a_amp_off_defer: assert property (conv_busy_o && $past(conv_busy_o) |-> !$fell(amp0_cfg_o.on) && !$fell(amp1_cfg_o.on))
    else $error("amplifier switched off during a conversion");
endmodule // acc_ctrl_chk

bind acc_ctrl acc_ctrl_chk chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adc_tick_i(adc_tick_i),
  .other_start_i(other_start_i), .amp_chg_i(amp_chg_i), .pin_in_o(pin_in_o),
  .buf_off_low_o(buf_off_low_o), .amp0_cfg_o(amp0_cfg_o), .amp1_cfg_o(amp1_cfg_o),
  .conv_busy_o(conv_busy_o), .other_ok_o(other_ok_o)
);

//--- acc_far_side.sv
`timescale 1ns/1ps
// Far side: converter clock ticks and the three stage controller event pins.
module acc_far_side
  import acc_pkg::*;
#(
  parameter int TICK_DIV = 4 // System clocks per converter clock.
) (
  input  wire logic       clk_i,          // System clock.
  input  wire logic       rst_i,          // Reset, active high.
  output logic            tick_o = 1'b0,  // Converter clock tick.
  output logic      [2:0] stage_o = 3'h0  // Stage event pins.
);
  logic [15:0] cnt_ff = 16'h0000; // Free-running time base.

  // The time base restarts with reset so that the tick phase is repeatable.
  always_ff @(posedge clk_i) begin
    cnt_ff <= rst_i ? 16'h0000 : cnt_ff + 16'h0001;
  end

  // Each stage pin pulses for four clocks every 40, 56 or 72 clocks, far below a
  // quarter of the converter rate, so the improved amplifier always keeps up.
  always_ff @(posedge clk_i) begin
    tick_o <= !rst_i && (int'(cnt_ff) % TICK_DIV == 0);
    for (int n = 0; n < 3; n++) begin
      stage_o[n] <= !rst_i && (int'(cnt_ff) % (40 + 16 * n) < 4);
    end
  end
endmodule // acc_far_side

//--- test_amplified_channel_conversion_control.sv
`timescale 1ns/1ps
// Random and corner-case traffic through the registers, with expectations from the rules.
module test_amplified_channel_conversion_control;
  import acc_pkg::*;
  localparam logic [7:0] C_GO   = 8'h01 << CONV_START_BIT;
  localparam logic [7:0] C_REQ  = 8'h01 << CONV_REQ_BIT;
  localparam logic [7:0] C_AUTO = 8'h01 << CONV_AUTO_BIT;
  localparam logic [7:0] C_NEW  = 8'h01 << CONV_REVB_BIT;
  localparam logic [7:0] C_SEL  = 8'h01 << CONV_AMPSEL_BIT;
  localparam logic [7:0] C_AMP  = 8'h01 << CONV_AMPCH_BIT;
  logic         clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic         auto_trig_i = 1'b0, other_start_i = 1'b0, amp_chg_i = 1'b0, ce_i = 1'b1;
  logic [7:0]   wb_adr_i = 8'h00, lfsr_ff = 8'h56, buf_off_low_o;
  logic [3:0]   wb_sel_i = 4'h0;
  logic [31:0]  wb_dat_i = 32'h00000000, wb_dat_o;
  logic [9:0]   conv_data_i = 10'h000;
  logic [10:0]  pin_raw_i = 11'h000, pin_in_o;
  logic         wb_ack_o, adc_tick_i, sample_o, conv_busy_o, other_ok_o;
  logic [2:0]   stage_evt_i;
  logic [5:0]   buf_off_high_o;
  acc_amp_cfg_t amp0_cfg_o, amp1_cfg_o;
  int           n_mismatch = 0, n_tests = 0;

  // A 50 MHz clock.
  always #10 clk_i = ~clk_i;

  acc_ctrl dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adc_tick_i(adc_tick_i),
    .stage_evt_i(stage_evt_i), .auto_trig_i(auto_trig_i), .other_start_i(other_start_i),
    .amp_chg_i(amp_chg_i), .conv_data_i(conv_data_i), .pin_raw_i(pin_raw_i),
    .pin_in_o(pin_in_o), .buf_off_low_o(buf_off_low_o), .buf_off_high_o(buf_off_high_o),
    .amp0_cfg_o(amp0_cfg_o), .amp1_cfg_o(amp1_cfg_o), .sample_o(sample_o),
    .conv_busy_o(conv_busy_o), .other_ok_o(other_ok_o)
  );
  acc_far_side #(.TICK_DIV(4)) far_u (
    .clk_i(clk_i), .rst_i(rst_i), .tick_o(adc_tick_i), .stage_o(stage_evt_i)
  );

  // Shift register with taps 8, 6, 5 and 4; the expected amplifier settings of a control byte.
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [3:0] cfg_of(input logic [7:0] c);
    return {c[AMP_ON_BIT], c[AMP_SHUNT_BIT], c[AMP_GAIN_LSB+1], c[AMP_GAIN_LSB]};
  endfunction
  task automatic rnd(output logic [7:0] v);
    lfsr_ff = lfsr(lfsr_ff);
    v = lfsr_ff;
  endtask

  // Verdict and counts; every exhausted wait ends here too.
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bounded wait on busy (0), sample (1), amplifier 0 on (2) or acknowledge (3).
  task automatic wait_on(input int which, input logic lvl, input int lim);
    logic s;
    s = ~lvl;
    for (int n = 0; s !== lvl; n++) begin
      if (n == lim) begin
        chk("wait", lvl, s);
        conclude();
      end
      @(posedge clk_i);
      s = (which == 0) ? conv_busy_o : (which == 1) ? sample_o :
          (which == 2) ? amp0_cfg_o.on : wb_ack_o;
    end
  endtask

  // Classic single Wishbone cycle; data is taken at the edge that sees acknowledge.
  task automatic wb_io(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                       output logic [7:0] rd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h000000, dat};
    wait_on(3, 1'b1, 50);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    logic [7:0] x;
    wb_io(1'b1, adr, dat, x);
  endtask

  // One plain start pulse, then 150 quiet cycles: the start is taken, no conversion begins.
  task automatic quiet();
    int nb;
    int nk;
    nb = 0;
    nk = 0;
    other_start_i <= 1'b1;
    @(posedge clk_i);
    other_start_i <= 1'b0;
    repeat (150) begin
      @(posedge clk_i);
      nb += int'(conv_busy_o !== 1'b0);
      nk += int'(other_ok_o === 1'b1);
    end
    chk("busy cycles", 32'h0, nb);
    chk("plain starts", 32'h1, nk);
    $display("test quiet done");
  endtask

  // One amplified conversion; mode 1 moves the amplifier in sample, mode 2 switches it off.
  task automatic run_conv(input logic [7:0] ctl, input int mode);
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] r;
    rnd(a);
    rnd(b);
    conv_data_i <= {b[1:0], a};
    wr(ADDR_CONV_CTRL, ctl);
    auto_trig_i <= ctl[CONV_AUTO_BIT];
    // The move lands two cycles after an immediate start, always inside the sample phase.
    amp_chg_i   <= (mode == 1);
    @(posedge clk_i);
    auto_trig_i <= 1'b0;
    amp_chg_i   <= 1'b0;
    wait_on(0, 1'b1, 400);
    other_start_i <= 1'b1;
    @(posedge clk_i);
    other_start_i <= 1'b0;
    if (mode == 1) wait_on(1, 1'b1, 100);
    wr(ADDR_CONV_CTRL, ctl & 8'hFC);
    if (mode == 2) begin
      wr(ADDR_AMP0_CTRL, 8'h00);
      chk("amp held on", 32'h1, amp0_cfg_o.on);
    end
    wb_io(1'b0, ADDR_CONV_CTRL, 8'h00, r);
    if (!ctl[CONV_AUTO_BIT]) chk("start, request", 32'h1, r[1:0]);
    wb_io(1'b0, ADDR_CONV_STATUS, 8'h00, r);
    chk("status busy", 32'h1, r[0]);
    wait_on(0, 1'b0, 400);
    if (mode == 2) wait_on(2, 1'b0, 20);
    wb_io(1'b0, ADDR_RESULT_LOW, 8'h00, r);
    chk("result low", a, r);
    wb_io(1'b0, ADDR_RESULT_HIGH, 8'h00, r);
    chk("result high", b[1:0], r);
    wb_io(1'b0, ADDR_CONV_CTRL, 8'h00, r);
    chk("start cleared", 32'h0, r[CONV_START_BIT]);
    $display("test conversion %h mode %0d done", ctl, mode);
  endtask

  // Main sequence.
  initial begin
    logic [7:0] r;
    logic [7:0] v;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      wb_io(1'b0, (i == 7) ? 8'h20 : 8'(i * 4), 8'h00, r);
      chk("reset value", 32'h0, r);
    end
    rnd(v);
    pin_raw_i <= 11'h7FF;
    wr(ADDR_PIN_DIS_LOW, v);
    wr(ADDR_PIN_DIS_HIGH, 8'hFF);
    wb_io(1'b0, ADDR_PIN_DIS_HIGH, 8'h00, r);
    chk("disable high", PIN_DIS_HIGH_MASK, r);
    chk("buffers high", 32'h3F, buf_off_high_o);
    chk("buffers low", v, buf_off_low_o);
    chk("pins low", {24'h0, ~v}, pin_in_o[7:0]);
    chk("pins high", 32'h0, pin_in_o[10:8]);
    // With the enable low the gated pins must hold although the raw levels move.
    ce_i      <= 1'b0;
    pin_raw_i <= 11'h000;
    repeat (4) @(posedge clk_i);
    chk("pins frozen", {24'h0, ~v}, pin_in_o[7:0]);
    ce_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("pins released", 32'h0, pin_in_o[7:0]);
    $display("test disables done");
    for (int i = 0; i < 4; i++) begin
      v = {1'b1, !i[0], i[1:0], 2'h3, i[1:0]};
      wr(ADDR_AMP0_CTRL, v);
      wr(ADDR_AMP1_CTRL, v ^ 8'hC0);
      wb_io(1'b0, ADDR_AMP1_CTRL, 8'h00, r);
      chk("amp1 ctrl", (v & AMP_CTRL_MASK) ^ 8'hC0, r);
      chk("amp0 cfg", cfg_of(v), amp0_cfg_o);
      chk("amp1 cfg", cfg_of(v ^ 8'hC0), amp1_cfg_o);
    end
    $display("test amplifier fields done");
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_AMP0_CTRL, 8'h80 | 8'(s));
      run_conv(C_AMP | C_REQ, 0);
    end
    wr(ADDR_AMP1_CTRL, 8'h82);
    run_conv(C_AMP | C_SEL | C_REQ, 0);
    for (int k = 0; k < 4; k++) begin
      rnd(v);
      repeat (v[2:0]) @(posedge clk_i);
      run_conv(C_AMP | C_NEW | C_GO, 0);
    end
    run_conv(C_AMP | C_NEW | C_GO, 1);
    run_conv(C_AMP | C_NEW | C_GO, 2);
    wr(ADDR_CONV_CTRL, C_AMP | C_REQ);
    quiet();
    wr(ADDR_CONV_CTRL, C_AMP);
    wb_io(1'b0, ADDR_CONV_CTRL, 8'h00, r);
    chk("request withdrawn", 32'h0, r[CONV_REQ_BIT]);
    wr(ADDR_AMP0_CTRL, 8'h80);
    run_conv(C_AMP | C_AUTO, 0);
    quiet();
    conclude();
  end
endmodule // test_amplified_channel_conversion_control
